// File: logic/path_gain_control.sv
`timescale 1ns/1ps

module path_gain_control
    import gain_ctrl_pkg::*;
#(
    parameter int RX_COARSE_GAIN_CAP = COARSE_GAIN_CAP,
    parameter int RX_COARSE_ATTEN_CAP = COARSE_ATTEN_CAP
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Register port
    input wire reg_req_s req,
    output logic [DATA_W-1:0] rd_data,
    // Decoded levels, 0.1 dB units, positive is gain
    output level_t rx_coarse_level,
    output level_t tx_fine_level,
    output level_t rx_fine_level,
    output level_t rx_path_level
);

    // Caps beyond the four-bit step field could never be reached
    if (RX_COARSE_GAIN_CAP < 1 || RX_COARSE_GAIN_CAP > 15) begin : g_bad_gain_cap
        $error("path_gain_control: coarse gain cap must lie in 1..15");
    end
    if (RX_COARSE_ATTEN_CAP < 1 || RX_COARSE_ATTEN_CAP > 15) begin : g_bad_atten_cap
        $error("path_gain_control: coarse attenuation cap must lie in 1..15");
    end

    localparam int NUM_REGS = 3;
    localparam int IDX_RXC = 0;
    localparam int IDX_TXF = 1;
    localparam int IDX_RXF = 2;

    typedef struct packed {
        gain_reg_s rx_coarse;
        gain_reg_s tx_fine;
        gain_reg_s rx_fine;
        logic [DATA_W-1:0] rd_data;
        level_t rxc;
        level_t txf;
        level_t rxf;
        level_t rxp;
    } state_s;

    state_s st;
    state_s next_st;
    gain_reg_s setting [NUM_REGS];
    level_t decoded [NUM_REGS];

    // Offset of each register, by index
    function automatic logic [ADDR_W-1:0] reg_offset(input int idx);
        case (idx)
            IDX_RXC: reg_offset = RX_COARSE_GAIN_OFS;
            IDX_TXF: reg_offset = TX_FINE_GAIN_OFS;
            default: reg_offset = RX_FINE_GAIN_OFS;
        endcase
    endfunction : reg_offset

    // Byte image of one setting; upper bits always zero
    function automatic logic [DATA_W-1:0] reg_image(input gain_reg_s g);
        logic [DATA_W-1:0] v;
        v = GAIN_REG_RESET;
        v[SIGN_POS] = g.sign;
        v[STEPS_LSB +: STEPS_W] = g.steps;
        reg_image = v;
    endfunction : reg_image

    // Setting carried by a written byte; reserved bits dropped
    function automatic gain_reg_s reg_field(input logic [DATA_W-1:0] d);
        gain_reg_s g;
        g.sign = d[SIGN_POS];
        g.steps = d[STEPS_LSB +: STEPS_W];
        reg_field = g;
    endfunction : reg_field

    assign setting[IDX_RXC] = st.rx_coarse;
    assign setting[IDX_TXF] = st.tx_fine;
    assign setting[IDX_RXF] = st.rx_fine;

    // Coarse path uses 1 dB steps with a lower cap on gain than on loss
    localparam int STEP_OF [NUM_REGS] = '{COARSE_STEP_TENTHS, FINE_STEP_TENTHS,
                                          FINE_STEP_TENTHS};
    localparam int GCAP_OF [NUM_REGS] = '{RX_COARSE_GAIN_CAP, FINE_CAP, FINE_CAP};
    localparam int ACAP_OF [NUM_REGS] = '{RX_COARSE_ATTEN_CAP, FINE_CAP, FINE_CAP};

    generate
        for (genvar i = 0; i < NUM_REGS; i++) begin : g_dec
            gain_decode #(
                .STEP_TENTHS(STEP_OF[i]),
                .GAIN_CAP(GCAP_OF[i]),
                .ATTEN_CAP(ACAP_OF[i])
            ) u_dec (
                .setting(setting[i]),
                .level(decoded[i])
            );
        end
    endgenerate

    always_comb begin
        next_st = st;
        // Read data live only in the cycle after the strobe
        next_st.rd_data = '0;
        if (req.wr) begin
            case (req.addr)
                RX_COARSE_GAIN_OFS: next_st.rx_coarse = reg_field(req.wdata);
                TX_FINE_GAIN_OFS: next_st.tx_fine = reg_field(req.wdata);
                RX_FINE_GAIN_OFS: next_st.rx_fine = reg_field(req.wdata);
                default: next_st.rx_coarse = st.rx_coarse;
            endcase
        end
        // A read beside a write would see the old value; the bus never sends both
        if (req.rd) begin
            case (req.addr)
                RX_COARSE_GAIN_OFS: next_st.rd_data = reg_image(st.rx_coarse);
                TX_FINE_GAIN_OFS: next_st.rd_data = reg_image(st.tx_fine);
                RX_FINE_GAIN_OFS: next_st.rd_data = reg_image(st.rx_fine);
                // Unmapped offsets answer zero
                default: next_st.rd_data = '0;
            endcase
        end
        // Levels follow the held settings one cycle later
        next_st.rxc = decoded[IDX_RXC];
        next_st.txf = decoded[IDX_TXF];
        next_st.rxf = decoded[IDX_RXF];
        // Coarse and fine stages in series add in dB
        next_st.rxp = level_t'(decoded[IDX_RXC] + decoded[IDX_RXF]);
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            // Code zero everywhere, so every path leaves reset at 0 dB
            st.rx_coarse <= reg_field(GAIN_REG_RESET);
            st.tx_fine <= reg_field(GAIN_REG_RESET);
            st.rx_fine <= reg_field(GAIN_REG_RESET);
            st.rd_data <= '0;
            st.rxc <= '0;
            st.txf <= '0;
            st.rxf <= '0;
            st.rxp <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign rd_data = st.rd_data;
    assign rx_coarse_level = st.rxc;
    assign tx_fine_level = st.txf;
    assign rx_fine_level = st.rxf;
    assign rx_path_level = st.rxp;

    // Checks on decoded levels against the settings one cycle earlier, against fixed bounds and against each other

    coarse_gain_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        (!st.rx_coarse.sign && st.rx_coarse.steps < 4'hc)
        |=> rx_coarse_level == level_t'(10 * int'($past(st.rx_coarse.steps))))
    else $error("coarse receive gain not 1 dB per step");

    coarse_atten_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        st.rx_coarse.sign
        |=> rx_coarse_level == level_t'(-10 * int'($past(st.rx_coarse.steps))))
    else $error("coarse receive attenuation not 1 dB per step");

    coarse_saturate_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        (!st.rx_coarse.sign && st.rx_coarse.steps[3:2] == 2'h3)
        |=> rx_coarse_level == 9'sd120)
    else $error("coarse receive gain does not saturate at 12 dB");

    coarse_deepest_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        (st.rx_coarse.sign && st.rx_coarse.steps == 4'hf)
        |=> rx_coarse_level == -9'sd150)
    else $error("coarse receive code 1111 is not 15 dB attenuation");

    coarse_bounds_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        rx_coarse_level >= -9'sd150 && rx_coarse_level <= 9'sd120)
    else $error("coarse receive level outside -15..+12 dB");

    zero_code_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        (st.rx_coarse.steps == 4'h0 && st.tx_fine.steps == 4'h0
         && st.rx_fine.steps == 4'h0)
        |=> rx_coarse_level == 0 && tx_fine_level == 0 && rx_fine_level == 0
            && rx_path_level == 0)
    else $error("step code 0000 does not give 0 dB");

    tx_fine_gain_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        !st.tx_fine.sign
        |=> tx_fine_level == level_t'(int'($past(st.tx_fine.steps))))
    else $error("fine transmit gain not 0.1 dB per step");

    tx_fine_atten_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        st.tx_fine.sign
        |=> tx_fine_level == level_t'(-int'($past(st.tx_fine.steps))))
    else $error("fine transmit attenuation steps unequal");

    tx_fine_max_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        (st.tx_fine.sign && st.tx_fine.steps == 4'hf) [*2]
        |-> tx_fine_level == -9'sd15)
    else $error("fine transmit code 1111 is not 1.5 dB attenuation");

    rx_fine_range_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        rx_fine_level >= -9'sd15 && rx_fine_level <= 9'sd15)
    else $error("fine receive level beyond 1.5 dB");

    rx_fine_dir_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        ##1 (($past(st.rx_fine.sign) && rx_fine_level <= 0)
             || (!$past(st.rx_fine.sign) && rx_fine_level >= 0)))
    else $error("fine receive sign does not set direction");

    rx_fine_step_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        1'b1
        |=> (rx_fine_level < 0 ? -rx_fine_level : rx_fine_level)
            == level_t'(int'($past(st.rx_fine.steps))))
    else $error("fine receive step is not 0.1 dB");

    rx_gain_max_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        (!st.rx_fine.sign && st.rx_fine.steps == 4'hf) |=> rx_fine_level == 9'sd15)
    else $error("fine receive largest gain is not 1.5 dB");

    rx_atten_max_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        (st.rx_fine.sign && st.rx_fine.steps == 4'hf) |=> rx_fine_level == -9'sd15)
    else $error("fine receive code 1111 is not 1.5 dB attenuation");

    rx_path_sum_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        rx_path_level == level_t'(rx_coarse_level + rx_fine_level))
    else $error("receive path level is not coarse plus fine");

    // Outer limits that hold in every cycle
    path_bounds_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        rx_path_level >= -9'sd165 && rx_path_level <= 9'sd135)
    else $error("receive path level outside -16.5..+13.5 dB");

    tx_fine_range_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        tx_fine_level >= -9'sd15 && tx_fine_level <= 9'sd15)
    else $error("fine transmit level beyond 1.5 dB");

    // Checks on register access
    reg_roundtrip_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        (req.wr && req.addr == RX_FINE_GAIN_OFS) ##1 (req.rd && req.addr == RX_FINE_GAIN_OFS
                                                      && !req.wr)
        |=> rd_data == {3'h0, $past(req.wdata[4:0], 2)})
    else $error("gain register does not read back sign and steps");

    reg_read_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        (req.rd && req.addr == RX_COARSE_GAIN_OFS)
        |=> rd_data == {3'h0, $past(st.rx_coarse.sign), $past(st.rx_coarse.steps)})
    else $error("coarse receive register read mismatch");

    tx_read_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        (req.rd && req.addr == TX_FINE_GAIN_OFS)
        |=> rd_data == {3'h0, $past(st.tx_fine.sign), $past(st.tx_fine.steps)})
    else $error("fine transmit register read mismatch");

    rx_read_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        (req.rd && req.addr == RX_FINE_GAIN_OFS)
        |=> rd_data == {3'h0, $past(st.rx_fine.sign), $past(st.rx_fine.steps)})
    else $error("fine receive register read mismatch");

    reg_write_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        (req.wr && req.addr == TX_FINE_GAIN_OFS)
        |=> st.tx_fine == $past(req.wdata[4:0]))
    else $error("fine transmit register write did not land");

    unmapped_write_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        (req.wr && req.addr != RX_COARSE_GAIN_OFS && req.addr != TX_FINE_GAIN_OFS
         && req.addr != RX_FINE_GAIN_OFS)
        |=> $stable(st.rx_coarse) && $stable(st.tx_fine) && $stable(st.rx_fine))
    else $error("write to an unmapped offset changed a setting");

    reserved_zero_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        rd_data[7:5] == 3'h0)
    else $error("reserved bits read nonzero");

    idle_read_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        !req.rd |=> rd_data == 8'h00)
    else $error("read data present without a read strobe");

    // No disable here, so the check runs while reset is held
    reset_clear_a: assert property (
        @(posedge clk_sys)
        !rst_n |=> rd_data == 8'h00 && rx_coarse_level == 0 && tx_fine_level == 0
            && rx_fine_level == 0 && rx_path_level == 0)
    else $error("reset does not clear read data and levels");

    // Main scenarios

    coarse_sat_c: cover property (
        @(posedge clk_sys) disable iff (!rst_n)
        rx_coarse_level == 9'sd120);

    coarse_deep_c: cover property (
        @(posedge clk_sys) disable iff (!rst_n)
        rx_coarse_level == -9'sd150);

    fine_both_c: cover property (
        @(posedge clk_sys) disable iff (!rst_n)
        tx_fine_level == -9'sd15 && rx_fine_level == 9'sd15);

    write_read_c: cover property (
        @(posedge clk_sys) disable iff (!rst_n)
        req.wr ##1 req.rd ##1 rd_data != 8'h00);

    mid_reset_c: cover property (
        @(posedge clk_sys)
        rst_n ##1 !rst_n ##1 !rst_n ##1 rst_n);

endmodule : path_gain_control

// File: logic/gain_ctrl_pkg.sv
package gain_ctrl_pkg;

    // Register port widths
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;

    // Register offsets
    localparam logic [ADDR_W-1:0] RX_COARSE_GAIN_OFS = 8'h27;
    localparam logic [ADDR_W-1:0] TX_FINE_GAIN_OFS = 8'h28;
    localparam logic [ADDR_W-1:0] RX_FINE_GAIN_OFS = 8'h29;

    // Field layout of every gain register
    localparam int SIGN_POS = 4;
    localparam int STEPS_LSB = 0;
    localparam int STEPS_W = 4;
    localparam int FIELD_W = 5;

    // Reset value of every gain register
    localparam logic [DATA_W-1:0] GAIN_REG_RESET = 8'h00;

    // Step sizes in units of 0.1 dB
    localparam int COARSE_STEP_TENTHS = 10;
    localparam int FINE_STEP_TENTHS = 1;

    // Largest step counts honoured in each direction
    localparam int COARSE_GAIN_CAP = 12;
    localparam int COARSE_ATTEN_CAP = 15;
    localparam int FINE_CAP = 15;

    // Signed level in 0.1 dB units, wide enough for -16.5 .. +13.5 dB
    localparam int LEVEL_W = 9;
    typedef logic signed [LEVEL_W-1:0] level_t;

    // One gain setting: direction and step count
    typedef struct packed {
        logic sign;
        logic [STEPS_W-1:0] steps;
    } gain_reg_s;

    // One request on the register port
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } reg_req_s;

endpackage : gain_ctrl_pkg

// File: logic/gain_decode.sv
`timescale 1ns/1ps

module gain_decode
    import gain_ctrl_pkg::*;
#(
    parameter int STEP_TENTHS = COARSE_STEP_TENTHS,
    parameter int GAIN_CAP = COARSE_GAIN_CAP,
    parameter int ATTEN_CAP = COARSE_ATTEN_CAP
) (
    // Setting to decode
    input wire gain_reg_s setting,
    // Signed level, 0.1 dB units, positive is gain
    output level_t level
);

    if (GAIN_CAP > 15 || ATTEN_CAP > 15 || GAIN_CAP < 1 || ATTEN_CAP < 1) begin : g_bad_cap
        $error("gain_decode: caps must lie in 1..15");
    end
    // Deepest code times the step must still fit the signed level
    if (STEP_TENTHS < 1 || STEP_TENTHS * 15 > 2 ** (LEVEL_W - 1) - 1) begin : g_bad_step
        $error("gain_decode: step size out of range");
    end

    always_comb begin
        int steps;
        int mag;
        steps = int'(setting.steps);
        mag = 0;
        if (setting.sign) begin
            // Deeper codes than the cap hold at the cap
            mag = (steps > ATTEN_CAP ? ATTEN_CAP : steps) * STEP_TENTHS;
        end else begin
            mag = (steps > GAIN_CAP ? GAIN_CAP : steps) * STEP_TENTHS;
        end
        // Code zero gives zero either way, since mag is then zero
        level = setting.sign ? level_t'(-mag) : level_t'(mag);
    end

endmodule : gain_decode

// File: tb/path_gain_control_tb.sv
`timescale 1ns/1ps

module path_gain_control_tb
    import gain_ctrl_pkg::*;
;

    // Clock and reset
    logic clk_sys;
    logic rst_n;
    // Register port
    reg_req_s req;
    logic [DATA_W-1:0] rd_data;
    // Decoded levels
    level_t rx_coarse_level;
    level_t tx_fine_level;
    level_t rx_fine_level;
    level_t rx_path_level;

    int num_errors;
    int compares;
    level_t exp_lvl[3];
    logic [ADDR_W-1:0] ofs[3];

    path_gain_control #(
        .RX_COARSE_GAIN_CAP(COARSE_GAIN_CAP),
        .RX_COARSE_ATTEN_CAP(COARSE_ATTEN_CAP)
    ) path_gain_control_i (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .req(req),
        .rd_data(rd_data),
        .rx_coarse_level(rx_coarse_level),
        .tx_fine_level(tx_fine_level),
        .rx_fine_level(rx_fine_level),
        .rx_path_level(rx_path_level)
    );

    always #4 clk_sys = ~clk_sys;

    task automatic end_sim();
        if (num_errors == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : end_sim

    task automatic chk(input string name, input logic [LEVEL_W-1:0] exp_v,
                       input logic [LEVEL_W-1:0] got);
        compares++;
        if (got !== exp_v) begin
            $display("MISMATCH %s expected %h seen %h", name, exp_v, got);
            num_errors++;
        end
    endtask : chk

    // One write cycle; the next call or a direct clear of req releases the strobe
    task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge clk_sys);
        req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    endtask : wr_reg

    // Read data is sampled in the single cycle after the strobe
    task automatic rd_reg(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
        @(posedge clk_sys);
        req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk_sys);
        req <= '0;
        #1;
        d = rd_data;
    endtask : rd_reg

    // Expected level in 0.1 dB units; kind 0 is coarse, others fine
    function automatic level_t expect_level(input int kind, input logic s,
                                            input logic [3:0] n);
        int mag;
        mag = (kind == 0) ? int'(n) * 10 : int'(n);
        if (kind == 0 && !s && n > 4'd12) begin
            mag = 120;
        end
        return level_t'(s ? -mag : mag);
    endfunction : expect_level

    task automatic chk_levels();
        chk("rx_coarse_level", exp_lvl[0], rx_coarse_level);
        chk("tx_fine_level", exp_lvl[1], tx_fine_level);
        chk("rx_fine_level", exp_lvl[2], rx_fine_level);
        chk("rx_path_level", level_t'(exp_lvl[0] + exp_lvl[2]), rx_path_level);
    endtask : chk_levels

    task automatic chk_cleared();
        logic [DATA_W-1:0] d;
        for (int k = 0; k < 3; k++) begin
            rd_reg(ofs[k], d);
            chk("cleared register", 9'h000, {1'b0, d});
            exp_lvl[k] = '0;
        end
        chk_levels();
    endtask : chk_cleared

    initial begin
        logic [DATA_W-1:0] d;
        clk_sys = 1'b0;
        rst_n = 1'b0;
        req = '0;
        num_errors = 0;
        compares = 0;
        ofs[0] = RX_COARSE_GAIN_OFS;
        ofs[1] = TX_FINE_GAIN_OFS;
        ofs[2] = RX_FINE_GAIN_OFS;
        repeat (20) @(posedge clk_sys);
        rst_n <= 1'b1;
        chk_cleared();

        // Every sign and step code of every register, reserved bits set on write
        for (int k = 0; k < 3; k++) begin
            for (int s = 0; s < 2; s++) begin
                for (int n = 0; n < 16; n++) begin
                    wr_reg(ofs[k], {3'b111, s[0], n[3:0]});
                    // Back to back read must see the new value
                    rd_reg(ofs[k], d);
                    chk("readback", {4'h0, s[0], n[3:0]}, {1'b0, d});
                    exp_lvl[k] = expect_level(k, s[0], n[3:0]);
                    chk_levels();
                    @(posedge clk_sys);
                    #1;
                    chk("rd_data idle", 9'h000, {1'b0, rd_data});
                end
            end
        end

        // Reserved-only write leaves the fields cleared
        wr_reg(ofs[1], 8'he0);
        rd_reg(ofs[1], d);
        chk("reserved only write", 9'h000, {1'b0, d});
        exp_lvl[1] = '0;

        // Unmapped neighbours neither store nor disturb
        wr_reg(8'h2a, 8'h0a);
        wr_reg(8'h26, 8'h0a);
        rd_reg(8'h2a, d);
        chk("unmapped read 2a", 9'h000, {1'b0, d});
        rd_reg(8'h26, d);
        chk("unmapped read 26", 9'h000, {1'b0, d});
        rd_reg(ofs[0], d);
        chk("coarse kept", 9'h01f, {1'b0, d});
        rd_reg(ofs[2], d);
        chk("fine kept", 9'h01f, {1'b0, d});
        chk_levels();

        // Gain in both rx stages summed on the path level
        wr_reg(ofs[0], 8'h0c);
        wr_reg(ofs[2], 8'h0f);
        @(posedge clk_sys);
        req <= '0;
        @(posedge clk_sys);
        #1;
        exp_lvl[0] = expect_level(0, 1'b0, 4'hc);
        exp_lvl[2] = expect_level(2, 1'b0, 4'hf);
        chk_levels();

        // Reset in mid-run clears everything again
        @(posedge clk_sys);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk_sys);
        rst_n <= 1'b1;
        chk_cleared();
        end_sim();
    end

endmodule : path_gain_control_tb
